// File: inc/pwm_timer_cfg.svh
// register offsets, field positions, reset values and timing counts of the pulse width timer
// included by the pin conditioner, the timer core and the bench; definitions only
`ifndef PWM_TIMER_CFG_SVH
`define PWM_TIMER_CFG_SVH
`define OFF_CTRL 8'h00
`define OFF_PRELOAD 8'h04
`define OFF_COUNT 8'h08
`define OFF_STATUS 8'h0c
`define OFF_PORT 8'h10
`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 6
`define CTRL_RUN 4
`define CTRL_EDGE 3
`define CTRL_PSC_HI 2
`define CTRL_PSC_LO 0
`define CTRL_RESET 8'h08
`define ST_FLAG 0
`define ST_IEN 1
`define ST_WAKE 2
`define ST_FILTER 3
`define PORT_DIR3 0
`define PORT_DATA3 1
`define PORT_PFDSEL 2
`define COUNT_FULL 8'hff
`define PSC_WIDTH 7
`endif

// File: inc/pwm_timer_pkg.sv
// types shared by the timer files
// no assumptions beyond a SystemVerilog compiler
package pwm_timer_pkg;
    typedef enum logic [1:0]
    {
        MODE_NONE = 2'b00,
        MODE_EVENT = 2'b01,
        MODE_TIMER = 2'b10,
        MODE_PULSE = 2'b11
    } mode_type;
    typedef enum logic [1:0]
    {
        PW_IDLE = 2'b00,
        PW_COUNT = 2'b01,
        PW_DONE = 2'b10
    } pw_state_type;
endpackage

// File: inc/pin_sync_if.sv
// carrier between the timer core and its pin conditioner
// assumes one clock domain, sys_clk
`timescale 1ns/100ps
interface pin_sync_if;
    logic filterOn;
    logic pinLevel;
    modport core (output filterOn, input pinLevel);
    modport cond (input filterOn, output pinLevel);
endinterface

// File: hdl/pin_conditioner.sv
// synchroniser and optional noise filter for the timer input pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"
module pin_conditioner
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic pinIn, // raw pin
    pin_sync_if.cond link // conditioned level out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic agree;
    assign agree = (s2_r == s3_r);
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            lvl_r <= 1'b1;
        end
        else
        begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // filter on: accept only a level seen on two successive samples
            if (!link.filterOn || agree)
                lvl_r <= link.filterOn ? s3_r : s2_r;
        end
    end
    assign link.pinLevel = lvl_r;
endmodule // pin_conditioner

// File: hdl/pulse_width_timer.sv
// 8-bit timer with pulse width measurement, overflow reload, wake-up and frequency divider output
// assumes one AHB-Lite master on sys_clk; the timer pin is asynchronous
// Functional notes
// - mode field bits 7 and 6 both one select pulse width measurement
// - in pulse and timer modes the counter advances on the system clock divided by the prescaler
// - after run is set the counter waits idle for an active pin edge
// - edge select zero: start on falling pin edge, stop on rising
// - edge select one: start on rising pin edge, stop on falling
// - end of pulse clears the run bit in hardware and halts counting
// - timer and event modes never clear the run bit themselves
// - value held after measurement; further edges ignored until run is set again
// - starting and stopping follow pin edges, not the static pin level
// - overflow in pulse mode raises interrupt, reloads and keeps counting
// - pull-high stays active while the pin is a counter input
// - divider output toggles on every overflow; counter reloads and continues
// - selection bit routes divider to the port pin, otherwise plain I/O
// - divider appears only while port bit 3 direction is output
// - port bit 3 data one passes the divider, zero forces the pin low
// - one option switches the filter for the timer input pin
// - pulse mode pin events are seen only at the next timer clock pulse; event mode counts raw sync edges
// - counter clock inhibited during counter reads and preload writes
// - every overflow sets the request flag; interrupt only when enabled
// - overflow with the request flag clear wakes from power-down regardless of interrupt enable
// - prescale code selects divide by one up to divide by 128
// - counter counts up from preload to full scale and overflows
// - preload write while stopped loads counter; while running at next overflow
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"
module pulse_width_timer
(
    input wire logic sys_clk, // 100 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic timerInputPin, // external pulse source
    input wire logic powerDown, // device halted
    output logic timerIrq, // interrupt request
    output logic wakeUp, // wake-up pulse
    output logic portA3Out, // port pin drive value
    output logic portA3Oe, // port pin drive enable
    output logic pullHighEn // pull-high on timer pin
);
    logic [7:0] ctrl_r;
    logic [7:0] preload_r;
    logic [7:0] count_r;
    logic flag_r;
    logic ien_r;
    logic filter_r;
    logic pullCfg_r;
    logic dir3_r;
    logic data3_r;
    logic pfdSel_r;
    logic pfd_r;
    logic [`PSC_WIDTH-1:0] psc_r;
    logic pinPrev_r;
    logic evPrev_r;
    logic apWr_r;
    logic apRd_r;
    logic [7:0] apAddr_r;
    logic irq_r;
    logic wake_r;
    logic oe_r;
    logic out_r;
    logic pull_r;
    logic [31:0] rdata_r;
    pwm_timer_pkg::pw_state_type pw_r;
    pwm_timer_pkg::pw_state_type pwNxt;
    pin_sync_if sync ();
    pin_conditioner u_cond
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .pinIn(timerInputPin),
        .link(sync.cond)
    );
    assign sync.filterOn = filter_r;
    // address phase decode
    wire apValid = hsel && hready && htrans[1];
    wire apWrite = apValid && hwrite;
    wire apRead = apValid && !hwrite;
    wire wrCtrl = apWr_r && (apAddr_r == `OFF_CTRL);
    wire wrPre = apWr_r && (apAddr_r == `OFF_PRELOAD);
    wire wrCount = apWr_r && (apAddr_r == `OFF_COUNT);
    wire wrStat = apWr_r && (apAddr_r == `OFF_STATUS);
    wire wrPort = apWr_r && (apAddr_r == `OFF_PORT);
    wire rdCount = apRead && (haddr[7:0] == `OFF_COUNT);
    // control field decode
    wire [1:0] modeBits = {ctrl_r[`CTRL_MODE_HI], ctrl_r[`CTRL_MODE_LO]};
    wire runBit = ctrl_r[`CTRL_RUN];
    wire edgeSel = ctrl_r[`CTRL_EDGE];
    wire [2:0] pscSel = ctrl_r[`CTRL_PSC_HI:`CTRL_PSC_LO];
    wire pulseMode = (modeBits == pwm_timer_pkg::MODE_PULSE);
    wire timerMode = (modeBits == pwm_timer_pkg::MODE_TIMER);
    wire eventMode = (modeBits == pwm_timer_pkg::MODE_EVENT);
    // prescaler tick: ratio 2**pscSel
    wire [`PSC_WIDTH-1:0] pscMask = `PSC_WIDTH'((8'h01 << pscSel) - 8'h01);
    wire pscTick = ((psc_r & pscMask) == pscMask);
    // pin sampled only at timer clock ticks
    wire pinNow = sync.pinLevel;
    wire pinRise = pscTick && pinNow && !pinPrev_r;
    wire pinFall = pscTick && !pinNow && pinPrev_r;
    wire startEdge = edgeSel ? pinRise : pinFall;
    wire stopEdge = edgeSel ? pinFall : pinRise;
    // event counter uses raw sync edges, opposite polarity to pulse start
    wire evRise = sync.pinLevel && !evPrev_r;
    wire evFall = !sync.pinLevel && evPrev_r;
    wire evEdge = edgeSel ? evFall : evRise;
    wire inhibit = rdCount || wrPre;
    wire pwCounting = pulseMode && runBit && (pw_r == pwm_timer_pkg::PW_COUNT);
    wire countEn = !inhibit &&
        ((pwCounting && pscTick && !stopEdge) ||
         (timerMode && runBit && pscTick) ||
         (eventMode && runBit && evEdge));
    wire overflow = countEn && (count_r == `COUNT_FULL);
    wire pwEnd = pwCounting && stopEdge;
    wire runAuto = pulseMode && pwEnd;
    // pulse width sequencing
    always_comb
    begin
        pwNxt = pw_r;
        unique case (pw_r)
            pwm_timer_pkg::PW_IDLE:
                if (pulseMode && runBit && startEdge)
                    pwNxt = pwm_timer_pkg::PW_COUNT;
            pwm_timer_pkg::PW_COUNT:
                if (!runBit || !pulseMode)
                    pwNxt = pwm_timer_pkg::PW_IDLE;
                else if (stopEdge)
                    pwNxt = pwm_timer_pkg::PW_DONE;
            pwm_timer_pkg::PW_DONE:
                if (runBit)
                    pwNxt = pwm_timer_pkg::PW_IDLE;
            default:
                pwNxt = pwm_timer_pkg::PW_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pw_r <= pwm_timer_pkg::PW_IDLE;
        else
            pw_r <= pwNxt;
    end
    // prescaler and pin history
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            psc_r <= '0;
            pinPrev_r <= 1'b1;
            evPrev_r <= 1'b1;
        end
        else
        begin
            psc_r <= psc_r + `PSC_WIDTH'(1);
            evPrev_r <= sync.pinLevel;
            if (pscTick)
                pinPrev_r <= pinNow;
        end
    end
    // bus address phase capture
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            apWr_r <= 1'b0;
            apRd_r <= 1'b0;
            apAddr_r <= 8'h00;
        end
        else
        begin
            apWr_r <= apWrite;
            apRd_r <= apRead;
            if (apValid)
                apAddr_r <= haddr[7:0];
        end
    end
    // control register; software write then hardware clear of run
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ctrl_r <= `CTRL_RESET;
        else if (wrCtrl)
            ctrl_r <= {hwdata[7:6], 1'b0, hwdata[4:0]};
        else if (runAuto)
            ctrl_r[`CTRL_RUN] <= 1'b0;
    end
    // preload and counter
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            preload_r <= 8'h00;
            count_r <= 8'h00;
        end
        else
        begin
            if (wrPre)
                preload_r <= hwdata[7:0];
            if (wrPre && !runBit)
                count_r <= hwdata[7:0];
            else if (wrCount)
                count_r <= hwdata[7:0];
            else if (overflow)
                count_r <= preload_r;
            else if (countEn)
                count_r <= count_r + 8'h01;
        end
    end
    // status: request flag, enable, filter and pull options
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flag_r <= 1'b0;
            ien_r <= 1'b0;
            filter_r <= 1'b1;
            pullCfg_r <= 1'b0;
        end
        else
        begin
            if (wrStat)
            begin
                ien_r <= hwdata[`ST_IEN];
                filter_r <= hwdata[`ST_FILTER];
                pullCfg_r <= hwdata[`ST_WAKE];
            end
            if (overflow)
                flag_r <= 1'b1;
            else if (wrStat)
                flag_r <= hwdata[`ST_FLAG];
        end
    end
    // port bits and divider toggle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            dir3_r <= 1'b1;
            data3_r <= 1'b0;
            pfdSel_r <= 1'b0;
            pfd_r <= 1'b0;
        end
        else
        begin
            if (wrPort)
            begin
                dir3_r <= hwdata[`PORT_DIR3];
                data3_r <= hwdata[`PORT_DATA3];
                pfdSel_r <= hwdata[`PORT_PFDSEL];
            end
            if (!pfdSel_r)
                pfd_r <= 1'b0;
            else if (overflow)
                pfd_r <= !pfd_r;
        end
    end
    // pin and event outputs, all registered
    wire pinDrive = pfdSel_r ? (pfd_r && data3_r) : data3_r;
    wire wakeNxt = overflow && powerDown && !flag_r;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            oe_r <= 1'b0;
            out_r <= 1'b0;
            pull_r <= 1'b0;
        end
        else
        begin
            irq_r <= overflow && ien_r;
            wake_r <= wakeNxt;
            oe_r <= !dir3_r;
            out_r <= pinDrive;
            pull_r <= pullCfg_r;
        end
    end
    // read data registered at the address phase; zero wait states
    wire [31:0] rdMux =
        (haddr[7:0] == `OFF_CTRL) ? {24'h000000, ctrl_r} :
        (haddr[7:0] == `OFF_PRELOAD) ? {24'h000000, preload_r} :
        (haddr[7:0] == `OFF_COUNT) ? {24'h000000, count_r} :
        (haddr[7:0] == `OFF_STATUS) ? {28'h0000000, filter_r, pullCfg_r, ien_r, flag_r} :
        (haddr[7:0] == `OFF_PORT) ? {29'h0000000, pfdSel_r, data3_r, dir3_r} : 32'h00000000;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            rdata_r <= 32'h00000000;
        else if (apRead)
            rdata_r <= rdMux;
    end
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign timerIrq = irq_r;
    assign wakeUp = wake_r;
    assign portA3Oe = oe_r;
    assign portA3Out = out_r;
    assign pullHighEn = pull_r;
    // checks
    sequence s_pulse_end;
        pwCounting && stopEdge && !wrCtrl;
    endsequence
    a_run_auto_clear: assert property (@(posedge sys_clk) disable iff (rst)
        s_pulse_end |=> !ctrl_r[`CTRL_RUN])
        else $error("run bit not cleared at pulse end");
    a_run_kept_other: assert property (@(posedge sys_clk) disable iff (rst)
        (!pulseMode && runBit && !wrCtrl) |=> runBit)
        else $error("run bit cleared without software");
    a_idle_no_count: assert property (@(posedge sys_clk) disable iff (rst)
        (pulseMode && pw_r != pwm_timer_pkg::PW_COUNT && !apWr_r) |=> $stable(count_r))
        else $error("counter moved outside a measured pulse");
    a_overflow_reload: assert property (@(posedge sys_clk) disable iff (rst)
        (overflow && !wrPre && !wrCount) |=> (count_r == $past(preload_r)))
        else $error("overflow did not reload");
    a_flag_on_ovf: assert property (@(posedge sys_clk) disable iff (rst)
        overflow |=> flag_r)
        else $error("request flag not set");
    a_irq_gated: assert property (@(posedge sys_clk) disable iff (rst)
        timerIrq |-> $past(ien_r))
        else $error("interrupt without enable");
    a_pfd_toggle: assert property (@(posedge sys_clk) disable iff (rst)
        (overflow && pfdSel_r && !wrPort) |=> (pfd_r != $past(pfd_r)))
        else $error("divider did not toggle");
    a_pfd_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (!data3_r && !wrPort) |=> ##1 !portA3Out)
        else $error("divider not forced low");
    a_inhibit_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (rdCount && !apWr_r) |=> $stable(count_r))
        else $error("counter moved during read");
    a_wake_ovf: assert property (@(posedge sys_clk) disable iff (rst)
        (overflow && powerDown && !flag_r) |=> wakeUp)
        else $error("no wake-up on overflow");
endmodule // pulse_width_timer

// File: verif/pulse_source_model.sv
// external pulse source that drives the timer input pin
// assumes the bench fires it just after a rising edge of sys_clk
`timescale 1ns/100ps
module pulse_source_model
(
    input wire logic sys_clk, // bench clock, used only to time the pulse
    input wire logic idleHigh, // level held between pulses
    input wire logic fire, // start one pulse
    input wire logic [15:0] pulseLen, // pulse length in clock cycles
    output logic pinOut // timer input pin
);
    logic inPulse = 1'b0;

    // the pin moves a few ns off the clock edge, as an unrelated source would
    assign #2 pinOut = inPulse ? !idleHigh : idleHigh;

    always @(posedge sys_clk)
    begin
        if (fire && !inPulse)
        begin
            #3;
            inPulse = 1'b1;
            repeat (pulseLen) @(posedge sys_clk);
            #3;
            inPulse = 1'b0;
        end
    end
endmodule // pulse_source_model

// File: verif/tb_pulse_width_timer.sv
// self-checking bench for the pulse width timer and its divider output
// assumes the design answers the bus with no wait states but does not rely on it
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"
module tb_pulse_width_timer;
    logic sys_clk = 1'b0;
    logic rst, hsel, hwrite, powerDown, idleHigh, fire, pinWire;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] pulseLen;
    logic hreadyout, hresp, timerIrq, wakeUp, portA3Out, portA3Oe, pullHighEn, lastOut;
    int fails = 0;
    int n_compared = 0;
    int irqSeen = 0;
    int wakeSeen = 0;
    int togSeen = 0;

    always #5 sys_clk = !sys_clk;

    pulse_width_timer dut_u
    (
        .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .timerInputPin(pinWire), .powerDown(powerDown), .timerIrq(timerIrq),
        .wakeUp(wakeUp), .portA3Out(portA3Out), .portA3Oe(portA3Oe), .pullHighEn(pullHighEn)
    );

    pulse_source_model src_u
    (
        .sys_clk(sys_clk), .idleHigh(idleHigh), .fire(fire), .pulseLen(pulseLen), .pinOut(pinWire)
    );

    // counts output pulses and divider toggles
    always @(posedge sys_clk)
    begin
        if (timerIrq === 1'b1) irqSeen++;
        if (wakeUp === 1'b1) wakeSeen++;
        if (portA3Out !== lastOut) togSeen++;
        lastOut = portA3Out;
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chkRange(input string what, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        n_compared++;
        if (!(got >= lo && got <= hi) || $isunknown(got))
        begin
            fails++;
            $display("[ERR] %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic waitReady();
        int k;
        k = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1 && k < 50)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 50)
        begin
            fails++;
            $display("[ERR] hreadyout expected 1 seen %b", hreadyout);
            give_verdict();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
        chk("hresp", 32'h00000000, {31'h00000000, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        busXfer(1'b1, a, d, x);
    endtask

    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        busXfer(1'b0, a, 32'h00000000, x);
        chk(what, e, x);
    endtask

    task automatic pulse(input int len);
        pulseLen <= len[15:0];
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        // the stop edge is only seen at the next prescaler tick, up to one tick late
        repeat (len + len / 16 + 12) @(posedge sys_clk);
    endtask

    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        powerDown = 1'b0;
        idleHigh = 1'b0;
        fire = 1'b0;
        pulseLen = 16'h0000;
        lastOut = 1'b0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdChk("ctrl reset", `OFF_CTRL, 32'h00000008);
        rdChk("status reset", `OFF_STATUS, 32'h00000008);
        rdChk("port reset", `OFF_PORT, 32'h00000001);
        rdChk("unmapped", 8'h14, 32'h00000000);
        $display("test reset done");

        // pin already low when run is set: no start until a real falling edge
        wr(`OFF_PRELOAD, 32'h00000000);
        wr(`OFF_CTRL, 32'h000000c0);
        wr(`OFF_CTRL, 32'h000000d0);
        repeat (20) @(posedge sys_clk);
        rdChk("ctrl waiting", `OFF_CTRL, 32'h000000d0);
        idleHigh <= 1'b1;
        repeat (20) @(posedge sys_clk);
        rdChk("count idle", `OFF_COUNT, 32'h00000000);
        pulse(30);
        rdChk("ctrl after pulse", `OFF_CTRL, 32'h000000c0);
        busXfer(1'b0, `OFF_COUNT, 32'h00000000, v);
        chkRange("falling pulse", 32'h0000001b, 32'h00000021, v);
        pulse(30);
        rdChk("count held", `OFF_COUNT, v);
        $display("test falling edge done");

        // rising start, every prescale code, pulse scaled to give 20 ticks
        idleHigh <= 1'b0;
        for (int p = 0; p < 8; p++)
        begin
            wr(`OFF_PRELOAD, 32'h00000000);
            wr(`OFF_CTRL, 32'h000000c8 | p);
            wr(`OFF_CTRL, 32'h000000d8 | p);
            pulse(20 << p);
            rdChk("ctrl rising", `OFF_CTRL, 32'h000000c8 | p);
            busXfer(1'b0, `OFF_COUNT, 32'h00000000, v);
            chkRange("prescaled pulse", 32'h00000012, 32'h00000016, v);
        end
        $display("test prescaler done");

        // overflow during a measurement reloads and keeps counting
        idleHigh <= 1'b1;
        wr(`OFF_STATUS, 32'h0000000a);
        wr(`OFF_PRELOAD, 32'h000000f0);
        wr(`OFF_CTRL, 32'h000000c0);
        wr(`OFF_CTRL, 32'h000000d0);
        irqSeen = 0;
        pulse(40);
        busXfer(1'b0, `OFF_COUNT, 32'h00000000, v);
        chkRange("count after wrap", 32'h000000f5, 32'h000000fb, v);
        chk("irq pulses", 32'd2, irqSeen);
        rdChk("status flag", `OFF_STATUS, 32'h0000000b);
        $display("test overflow done");

        // timer mode drives the divider output
        wr(`OFF_PRELOAD, 32'h000000fc);
        wr(`OFF_PORT, 32'h00000006);
        wr(`OFF_CTRL, 32'h00000080);
        wr(`OFF_CTRL, 32'h00000090);
        togSeen = 0;
        repeat (80) @(posedge sys_clk);
        chkRange("divider toggles", 32'd18, 32'd21, togSeen);
        chk("divider oe", 32'd1, {31'd0, portA3Oe});
        rdChk("ctrl timer run", `OFF_CTRL, 32'h00000090);
        busXfer(1'b0, `OFF_COUNT, 32'h00000000, v);
        wr(`OFF_PORT, 32'h00000004);
        repeat (4) @(posedge sys_clk);
        togSeen = 0;
        repeat (20) @(posedge sys_clk);
        chk("gated toggles", 32'd0, togSeen);
        chk("gated level", 32'd0, {31'd0, portA3Out});
        wr(`OFF_PORT, 32'h00000005);
        repeat (2) @(posedge sys_clk);
        chk("input oe", 32'd0, {31'd0, portA3Oe});
        wr(`OFF_PORT, 32'h00000002);
        repeat (4) @(posedge sys_clk);
        togSeen = 0;
        repeat (20) @(posedge sys_clk);
        chk("plain io level", 32'd1, {31'd0, portA3Out});
        chk("plain io toggles", 32'd0, togSeen);
        $display("test divider done");

        // wake-up from power-down with the interrupt disabled; timer stopped first so flag clear sticks
        wr(`OFF_CTRL, 32'h00000080);
        wr(`OFF_STATUS, 32'h0000000c);
        wr(`OFF_PRELOAD, 32'h000000fc);
        powerDown <= 1'b1;
        wakeSeen = 0;
        irqSeen = 0;
        wr(`OFF_CTRL, 32'h00000090);
        repeat (20) @(posedge sys_clk);
        chk("wake pulses", 32'd1, wakeSeen);
        chk("irq disabled", 32'd0, irqSeen);
        chk("pull-high", 32'd1, {31'd0, pullHighEn});
        wr(`OFF_CTRL, 32'h00000080);
        wr(`OFF_STATUS, 32'h0000000c);
        wr(`OFF_STATUS, 32'h0000000d);
        wakeSeen = 0;
        wr(`OFF_CTRL, 32'h00000090);
        repeat (30) @(posedge sys_clk);
        chk("wake suppressed", 32'd0, wakeSeen);
        powerDown <= 1'b0;
        $display("test wake done");

        // event mode counts rising pin edges and keeps its run bit
        wr(`OFF_CTRL, 32'h00000040);
        wr(`OFF_PRELOAD, 32'h00000000);
        wr(`OFF_CTRL, 32'h00000050);
        pulse(10);
        pulse(10);
        rdChk("event count", `OFF_COUNT, 32'h00000002);
        rdChk("ctrl event run", `OFF_CTRL, 32'h00000050);
        $display("test event done");
        give_verdict();
    end
endmodule // tb_pulse_width_timer
